// file: rtl/status_event_pkg.sv
// status event reporter package: event codes, field widths, slot masks
// assumes both ends of the report link import it
package status_event_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int EVT_W = 8;    // event type field width
    localparam int CHAN_W = 8;   // channel identifier width
    localparam int SVC_W = 20;   // downstream service identifier width
    localparam int PROF_W = 8;   // profile identifier width
    localparam int XACT_W = 8;   // transaction identifier width
    // ************************************************************
    // event type codes
    // ************************************************************
    localparam logic [7:0] EVT_SEC_DESC_TIMEOUT = 8'h01;
    localparam logic [7:0] EVT_LOCK_FAIL = 8'h02;
    localparam logic [7:0] EVT_SEQ_RANGE = 8'h03;
    localparam logic [7:0] EVT_SEC_DESC_RECOVER = 8'h04;
    localparam logic [7:0] EVT_LOCK_RECOVER = 8'h05;
    localparam logic [7:0] EVT_MAINT_TIMEOUT = 8'h06;
    localparam logic [7:0] EVT_RANGING_RETRIES = 8'h07;
    localparam logic [7:0] EVT_RANGING_OK = 8'h08;
    localparam logic [7:0] EVT_OFDM_PROF_FAIL = 8'h10;
    localparam logic [7:0] EVT_PRIMARY_CHANGE = 8'h11;
    localparam logic [7:0] EVT_PROF_DESC_MISMATCH = 8'h12;
    localparam logic [7:0] EVT_CW_PTR_FAIL = 8'h14;
    localparam logic [7:0] EVT_PHY_LINK_FAIL = 8'h15;
    localparam logic [7:0] EVT_CW_PTR_RECOVER = 8'h16;
    localparam logic [7:0] EVT_PHY_LINK_RECOVER = 8'h17;
    localparam logic [7:0] EVT_OFDM_PROF_RECOVER = 8'h18;
    localparam logic [7:0] EVT_OFDMA_PROF_FAIL = 8'h19;
    localparam logic [7:0] EVT_MAP_OVERFLOW = 8'h1A;
    localparam logic [7:0] EVT_MAP_ALMOST_FULL = 8'h1B;
    localparam logic [7:0] EVT_FIRST_RESERVED = 8'h1C;
    // ************************************************************
    // parameter slot mask bits
    // ************************************************************
    localparam int SLOT_DS_CHAN = 0;  // downstream channel id present
    localparam int SLOT_US_CHAN = 1;  // upstream channel id present
    localparam int SLOT_SVC = 2;      // service identifier present
    localparam int SLOT_PROF = 3;     // profile id present
    localparam int SLOT_N = 4;
    // ************************************************************
    // timing
    // ************************************************************
    localparam logic [15:0] ANSWER_WAIT = 16'h0400;  // cycles of silence before a resend
endpackage

// file: rtl/status_link_if.sv
// report and acknowledge link between modem and head-end ends
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface status_link_if
    import status_event_pkg::*;
    ();
    logic rptValid;                 // report strobe, held until rptReady
    logic rptReady;                 // head-end takes report
    logic [EVT_W-1:0] rptEvent;     // event type
    logic [XACT_W-1:0] rptXact;     // transaction id
    logic [SLOT_N-1:0] rptSlots;    // which parameter slots are present
    logic [CHAN_W-1:0] rptDsChan;   // downstream channel id
    logic [CHAN_W-1:0] rptUsChan;   // upstream channel id
    logic [SVC_W-1:0] rptSvc;       // downstream_service_identifier
    logic [PROF_W-1:0] rptProf;     // profile id
    logic ackValid;                 // one-cycle acknowledge pulse
    logic [EVT_W-1:0] ackEvent;
    logic [XACT_W-1:0] ackXact;
    logic descValid;                // one-cycle new descriptor pulse
    logic [EVT_W-1:0] descEvent;    // event whose controls change
    modport modem (output rptValid, rptEvent, rptXact, rptSlots, rptDsChan, rptUsChan,
        rptSvc, rptProf, input rptReady, ackValid, ackEvent, ackXact, descValid, descEvent);
    modport headend (input rptValid, rptEvent, rptXact, rptSlots, rptDsChan, rptUsChan,
        rptSvc, rptProf, output rptReady, ackValid, ackEvent, ackXact, descValid, descEvent);
endinterface
`default_nettype wire

// file: rtl/modem_status_event_reporter.sv
// modem end: turns raised status events into reports with the right slots
// assumes head-end end on the same clock; event inputs are same-domain logic
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - almost-full map event 27, upstream channel only
// - codes 28 to 255 never reported
// - types 1 and 4 carry channel id
// - types 2 and 5 carry channel id
// - type 3 carries service identifier only
// - types 6, 7, 8 carry channel id
// - type 16 carries channel and profile
// - type 17 carries new primary channel
// - type 18 carries channel and profile
// - types 20 and 22 carry channel id
// - types 21 and 23 carry channel id
// - type 24 carries channel and profile
// - type 25 carries upstream channel and profile
// - types 26 and 27 carry channel id
// - no acknowledge unless capability advertised
// - repeat report gets acknowledge again
// - head-end acks, sends descriptor, or stays silent
// - map overflow raises event 26
module modem_status_event_reporter
    import status_event_pkg::*;
    #(
    parameter int MAX_REPORTS = 3   // reports sent before giving up on ack
    ) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    status_link_if.modem link,
    input wire logic evtValid,                  // raise an event, one cycle
    input wire logic [EVT_W-1:0] evtType,
    input wire logic [CHAN_W-1:0] evtChan,      // channel of trigger
    input wire logic [SVC_W-1:0] evtSvc,        // downstream_service_identifier
    input wire logic [PROF_W-1:0] evtProf,      // profile of trigger
    input wire logic mapOverflow,               // map info elements exceed storage
    input wire logic mapAlmostFull,             // map storage nearing capacity
    input wire logic [CHAN_W-1:0] mapChan,      // upstream channel of map trigger
    output logic evtTaken,                      // event accepted
    output logic evtDropped,                    // reserved or busy, pulse
    output logic [1:0] doneCode                 // last outcome: 1 ack, 2 desc, 3 gave up
    );
    // ************************************************************
    // types and state
    // ************************************************************
    typedef enum logic [1:0] {
        IDLE = 2'b00,   // nothing pending
        SEND = 2'b01,   // report on the link
        WAIT = 2'b10    // waiting for head-end answer
    } state_t;
    state_t state_q, state_d;
    logic [EVT_W-1:0] evt_q, evt_d;
    logic [XACT_W-1:0] xact_q, xact_d;
    logic [SLOT_N-1:0] slots_q, slots_d;
    logic [CHAN_W-1:0] dsChan_q, dsChan_d, usChan_q, usChan_d;
    logic [SVC_W-1:0] svc_q, svc_d;
    logic [PROF_W-1:0] prof_q, prof_d;
    logic [7:0] tries_q, tries_d;       // reports sent for current event
    logic [15:0] wait_q, wait_d;        // cycles waited for an answer
    logic [1:0] done_q, done_d;
    logic mapOvPrev_q, mapAfPrev_q;     // edge detect on map levels
    logic ovEdge, afEdge;
    logic [EVT_W-1:0] selType;
    logic [CHAN_W-1:0] selChan;
    logic selValid;
    logic [SLOT_N-1:0] selSlots;

    // map storage events are raised on the rising edge of their level
    assign ovEdge = mapOverflow & ~mapOvPrev_q;
    assign afEdge = mapAlmostFull & ~mapAfPrev_q;

    // ************************************************************
    // slot selection per event type
    // ************************************************************
    // map events take priority over the generic input; a generic event lost
    // in the same cycle is reported as dropped
    always_comb begin
        selType = evtType;
        selChan = evtChan;
        selValid = evtValid;
        if (ovEdge) begin
            selType = EVT_MAP_OVERFLOW;
            selChan = mapChan;
            selValid = 1'b1;
        end else if (afEdge) begin
            selType = EVT_MAP_ALMOST_FULL;
            selChan = mapChan;
            selValid = 1'b1;
        end
        selSlots = '0;
        unique case (selType)
            EVT_SEC_DESC_TIMEOUT, EVT_SEC_DESC_RECOVER: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
            end
            EVT_LOCK_FAIL, EVT_LOCK_RECOVER: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
            end
            EVT_SEQ_RANGE: begin
                selSlots[SLOT_SVC] = 1'b1;
            end
            EVT_MAINT_TIMEOUT, EVT_RANGING_RETRIES, EVT_RANGING_OK: begin
                selSlots[SLOT_US_CHAN] = 1'b1;
            end
            EVT_OFDM_PROF_FAIL: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
                selSlots[SLOT_PROF] = 1'b1;
            end
            EVT_PRIMARY_CHANGE: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
            end
            EVT_PROF_DESC_MISMATCH: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
                selSlots[SLOT_PROF] = 1'b1;
            end
            EVT_CW_PTR_FAIL, EVT_CW_PTR_RECOVER: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
            end
            EVT_PHY_LINK_FAIL, EVT_PHY_LINK_RECOVER: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
            end
            EVT_OFDM_PROF_RECOVER: begin
                selSlots[SLOT_DS_CHAN] = 1'b1;
                selSlots[SLOT_PROF] = 1'b1;
            end
            EVT_OFDMA_PROF_FAIL: begin
                selSlots[SLOT_US_CHAN] = 1'b1;
                selSlots[SLOT_PROF] = 1'b1;
            end
            EVT_MAP_OVERFLOW, EVT_MAP_ALMOST_FULL: begin
                selSlots[SLOT_US_CHAN] = 1'b1;
            end
            default: begin
                selValid = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // report sequencing
    // ************************************************************
    // only one event in flight; a new one while busy is dropped, the
    // trade for having no queue
    always_comb begin
        state_d = state_q;
        evt_d = evt_q;
        xact_d = xact_q;
        slots_d = slots_q;
        dsChan_d = dsChan_q;
        usChan_d = usChan_q;
        svc_d = svc_q;
        prof_d = prof_q;
        tries_d = tries_q;
        wait_d = wait_q;
        done_d = done_q;
        evtTaken = 1'b0;
        evtDropped = 1'b0;
        unique case (state_q)
            IDLE: begin
                // a frozen clock latches nothing, so the event counts as dropped
                if (selValid && clkEn) begin
                    evtTaken = 1'b1;
                    state_d = SEND;
                    evt_d = selType;
                    xact_d = xact_q + 8'h01;
                    slots_d = selSlots;
                    // unlisted slots are zeroed and flagged absent
                    dsChan_d = selSlots[SLOT_DS_CHAN] ? selChan : '0;
                    usChan_d = selSlots[SLOT_US_CHAN] ? selChan : '0;
                    svc_d = selSlots[SLOT_SVC] ? evtSvc : '0;
                    prof_d = selSlots[SLOT_PROF] ? evtProf : '0;
                    tries_d = 8'h00;
                end
                evtDropped = (evtValid & ~evtTaken) | (evtValid & (ovEdge | afEdge));
            end
            SEND: begin
                evtDropped = evtValid | ovEdge | afEdge;
                if (link.rptReady) begin
                    state_d = WAIT;
                    tries_d = tries_q + 8'h01;
                    wait_d = 16'h0000;
                end
            end
            WAIT: begin
                evtDropped = evtValid | ovEdge | afEdge;
                wait_d = wait_q + 16'h0001;
                if (link.ackValid && link.ackEvent == evt_q && link.ackXact == xact_q) begin
                    state_d = IDLE;
                    done_d = 2'h1;
                end else if (link.descValid && link.descEvent == evt_q) begin
                    state_d = IDLE;
                    done_d = 2'h2;
                end else if (wait_q == ANSWER_WAIT - 16'h0001) begin
                    // silence: resend same transaction up to the maximum
                    if (tries_q >= 8'(MAX_REPORTS)) begin
                        state_d = IDLE;
                        done_d = 2'h3;
                    end else begin
                        state_d = SEND;
                    end
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= IDLE;
            evt_q <= '0;
            xact_q <= '0;
            slots_q <= '0;
            dsChan_q <= '0;
            usChan_q <= '0;
            svc_q <= '0;
            prof_q <= '0;
            tries_q <= '0;
            wait_q <= '0;
            done_q <= '0;
            mapOvPrev_q <= 1'b0;
            mapAfPrev_q <= 1'b0;
        end else if (clkEn) begin
            state_q <= state_d;
            evt_q <= evt_d;
            xact_q <= xact_d;
            slots_q <= slots_d;
            dsChan_q <= dsChan_d;
            usChan_q <= usChan_d;
            svc_q <= svc_d;
            prof_q <= prof_d;
            tries_q <= tries_d;
            wait_q <= wait_d;
            done_q <= done_d;
            mapOvPrev_q <= mapOverflow;
            mapAfPrev_q <= mapAlmostFull;
        end
    end

    // link outputs straight from registers
    assign link.rptValid = (state_q == SEND);
    assign link.rptEvent = evt_q;
    assign link.rptXact = xact_q;
    assign link.rptSlots = slots_q;
    assign link.rptDsChan = dsChan_q;
    assign link.rptUsChan = usChan_q;
    assign link.rptSvc = svc_q;
    assign link.rptProf = prof_q;
    assign doneCode = done_q;
endmodule
`default_nettype wire

// file: rtl/headend_status_responder.sv
// head-end end: takes status reports and answers per policy
// assumes modem end on the same clock
`timescale 1ns/1ns
`default_nettype none
module headend_status_responder
    import status_event_pkg::*;
    (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    status_link_if.headend link,
    input wire logic ackCapable,            // modem advertised ack capability
    input wire logic [1:0] policy,          // 0 ack, 1 descriptor, 2/3 silent
    output logic rptSeen,                   // report taken, pulse
    output logic [EVT_W-1:0] lastEvent      // last report's event
    );
    // ************************************************************
    // answer logic
    // ************************************************************
    logic ack_q, ack_d, desc_q, desc_d;
    logic [EVT_W-1:0] ev_q, ev_d;
    logic [XACT_W-1:0] xa_q, xa_d;

    assign link.rptReady = 1'b1;    // always takes a report at once
    assign rptSeen = link.rptValid;

    // every report, repeated or not, gets the same answer again
    always_comb begin
        ack_d = 1'b0;
        desc_d = 1'b0;
        ev_d = ev_q;
        xa_d = xa_q;
        if (link.rptValid) begin
            ev_d = link.rptEvent;
            xa_d = link.rptXact;
            if (policy == 2'h0 && ackCapable) begin
                ack_d = 1'b1;
            end else if (policy == 2'h1) begin
                desc_d = 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            desc_q <= 1'b0;
            ev_q <= '0;
            xa_q <= '0;
        end else if (clkEn) begin
            ack_q <= ack_d;
            desc_q <= desc_d;
            ev_q <= ev_d;
            xa_q <= xa_d;
        end
    end

    assign link.ackValid = ack_q;
    assign link.ackEvent = ev_q;
    assign link.ackXact = xa_q;
    assign link.descValid = desc_q;
    assign link.descEvent = ev_q;
    assign lastEvent = ev_q;
endmodule
`default_nettype wire

// file: test/status_link_checker.sv
// checker for the report link: slot choice, answers and their pairing
// assumes it is instantiated beside the link interface in the bench
`timescale 1ns/1ns
`default_nettype none
module status_link_checker
    import status_event_pkg::*;
    (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rptValid,
    input wire logic rptReady,
    input wire logic [EVT_W-1:0] rptEvent,
    input wire logic [XACT_W-1:0] rptXact,
    input wire logic [SLOT_N-1:0] rptSlots,
    input wire logic ackValid,
    input wire logic [EVT_W-1:0] ackEvent,
    input wire logic [XACT_W-1:0] ackXact,
    input wire logic descValid,
    input wire logic [EVT_W-1:0] descEvent
    );
    // ************************************************************
    // properties, one clock, reset disables all
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // reserved codes never leave the modem
    property p_no_reserved;
        rptValid |-> rptEvent inside {[1:8], [16:18], [20:27]};
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved code sent");
    // service identifier alone for sequence range
    property p_seq_slots;
        rptValid && rptEvent == 8'h03 |-> rptSlots == 4'h4;
    endproperty
    a_seq_slots: assert property (p_seq_slots) else $error("type 3 slots wrong");
    // map and ranging events: upstream channel only
    property p_us_slots;
        rptValid && rptEvent inside {[6:8], 26, 27} |-> rptSlots == 4'h2;
    endproperty
    a_us_slots: assert property (p_us_slots) else $error("us slots wrong");
    // downstream profile events carry channel and profile
    property p_prof_slots;
        rptValid && rptEvent inside {16, 18, 24} |-> rptSlots == 4'h9;
    endproperty
    a_prof_slots: assert property (p_prof_slots) else $error("ds prof slots wrong");
    // upstream profile failure
    property p_usprof_slots;
        rptValid && rptEvent == 8'h19 |-> rptSlots == 4'hA;
    endproperty
    a_usprof_slots: assert property (p_usprof_slots) else $error("type 25 slots wrong");
    // downstream channel only
    property p_ds_slots;
        rptValid && rptEvent inside {1, 2, 4, 5, 17, [20:23]} |-> rptSlots == 4'h1;
    endproperty
    a_ds_slots: assert property (p_ds_slots) else $error("ds slots wrong");
    // an acknowledge answers the report taken one cycle before
    property p_ack_pair;
        ackValid |-> $past(rptValid && rptReady) && ackEvent == $past(rptEvent)
            && ackXact == $past(rptXact);
    endproperty
    a_ack_pair: assert property (p_ack_pair) else $error("ack does not match report");
    // a descriptor names the reported event
    property p_desc_pair;
        descValid |-> $past(rptValid) && descEvent == $past(rptEvent);
    endproperty
    a_desc_pair: assert property (p_desc_pair) else $error("descriptor mismatch");
    // one answer kind per report, and each a single pulse
    property p_one_answer;
        ackValid || descValid |-> !(ackValid && descValid) ##1 !(ackValid || descValid);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("double answer");
    c_ack: cover property (ackValid);
    c_desc: cover property (descValid);
    c_almost: cover property (rptValid && rptEvent == 8'h1B);
    c_resend: cover property (rptValid && rptXact == $past(rptXact, 2));
endmodule
`default_nettype wire

// file: test/modem_status_event_reporter_bench.sv
// self-checking bench: modem end and head-end end joined by the link
// assumes one 100 MHz clock; report limit shortened to 2 (one resend)
`timescale 1ns/1ns
`default_nettype none
module modem_status_event_reporter_bench;
    import status_event_pkg::*;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    localparam int MAXR = 2; // fewer resends keeps silent runs short
    logic ref_clk = 1'b0;
    logic nrst = 1'b0; // held low for 20 cycles
    logic clkEn = 1'b1;
    logic evtValid = 1'b0, mapOverflow = 1'b0, mapAlmostFull = 1'b0, ackCapable = 1'b1;
    logic [7:0] evtType = 8'h00, evtChan = 8'h00, evtProf = 8'h00, mapChan = 8'h00;
    logic [19:0] evtSvc = 20'h00000;
    logic [1:0] policy = 2'h0;
    logic evtTaken, evtDropped;
    logic [1:0] doneCode;
    logic rptSeen; // head-end saw a report
    logic [7:0] lastEvent; // head-end's last reported event
    int err_total = 0;
    int compares = 0;
    logic [7:0] expXact = 8'h00; // ids count up per accepted event
    logic [7:0] legal [19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B};
    logic [7:0] rsv [6] = '{8'h00, 8'h09, 8'h0F, 8'h13, 8'h1C, 8'hFF}; // refused codes
    status_link_if link();
    modem_status_event_reporter #(.MAX_REPORTS(MAXR)) i_modem_status_event_reporter(
        .ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .link(link), .evtValid(evtValid),
        .evtType(evtType), .evtChan(evtChan), .evtSvc(evtSvc), .evtProf(evtProf),
        .mapOverflow(mapOverflow), .mapAlmostFull(mapAlmostFull), .mapChan(mapChan),
        .evtTaken(evtTaken), .evtDropped(evtDropped), .doneCode(doneCode));
    headend_status_responder i_headend_status_responder(.ref_clk(ref_clk), .nrst(nrst),
        .clkEn(clkEn), .link(link), .ackCapable(ackCapable), .policy(policy),
        .rptSeen(rptSeen), .lastEvent(lastEvent));
    status_link_checker i_status_link_checker(.ref_clk(ref_clk), .nrst(nrst),
        .rptValid(link.rptValid), .rptReady(link.rptReady), .rptEvent(link.rptEvent),
        .rptXact(link.rptXact), .rptSlots(link.rptSlots), .ackValid(link.ackValid),
        .ackEvent(link.ackEvent), .ackXact(link.ackXact), .descValid(link.descValid),
        .descEvent(link.descEvent));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic end_sim();
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask
    // slots each event type must carry, zero for refused codes
    function automatic logic [3:0] exp_slots(input logic [7:0] t);
        case (t)
            8'h03: return 4'h4;
            8'h06, 8'h07, 8'h08, 8'h1A, 8'h1B: return 4'h2;
            8'h10, 8'h12, 8'h18: return 4'h9;
            8'h19: return 4'hA;
            8'h01, 8'h02, 8'h04, 8'h05, 8'h11: return 4'h1;
            8'h14, 8'h15, 8'h16, 8'h17: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction
    // bounded wait for a report; a timeout ends the run
    task automatic wait_rpt(input int bound);
        int n;
        n = 0;
        while (link.rptValid !== 1'b1 && n < bound) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= bound) begin
            err_total++;
            $display("unexpected at %0t: no report", $time);
            end_sim();
        end
    endtask
    // raise one event, then follow the report to its outcome
    task automatic run_evt(input logic [7:0] t, input logic [1:0] pol, input logic cap);
        logic [3:0] s;
        s = exp_slots(t);
        @(posedge ref_clk);
        policy <= pol;
        ackCapable <= cap;
        evtType <= t;
        evtChan <= 8'($urandom);
        evtSvc <= 20'($urandom);
        evtProf <= 8'($urandom);
        mapChan <= 8'($urandom);
        evtValid <= (t != 8'h1A && t != 8'h1B);
        mapOverflow <= (t == 8'h1A); // rising level raises overflow
        mapAlmostFull <= (t == 8'h1B);
        @(negedge ref_clk);
        check(evtDropped, s == 4'h0);
        check(evtTaken, s != 4'h0);
        @(posedge ref_clk);
        evtValid <= 1'b0;
        mapOverflow <= 1'b0;
        mapAlmostFull <= 1'b0;
        if (s == 4'h0) begin
            // refused: nothing may appear on the link
            repeat (4) begin
                @(negedge ref_clk);
                check(link.rptValid, 1'b0);
            end
            return;
        end
        expXact = expXact + 8'h01;
        wait_rpt(4);
        check(link.rptEvent, t);
        check(link.rptSlots, s);
        check(link.rptXact, expXact);
        check(rptSeen, 1'b1);
        check(link.rptDsChan, s[0] ? evtChan : 8'h00);
        check(link.rptUsChan, s[1] ? (t > 8'h19 ? mapChan : evtChan) : 8'h00);
        check(link.rptSvc, s[2] ? evtSvc : 20'h00000);
        check(link.rptProf, s[3] ? evtProf : 8'h00);
        @(negedge ref_clk);
        check(lastEvent, t);
        if (pol == 2'h0 && cap) begin
            check(link.ackValid, 1'b1);
            check(link.ackXact, expXact);
            @(negedge ref_clk);
            check(doneCode, 2'h1);
        end else if (pol == 2'h1) begin
            check(link.descValid, 1'b1);
            check(link.descEvent, t);
            @(negedge ref_clk);
            check(doneCode, 2'h2);
        end else begin
            // silent answer: resends keep the id, a new event is refused meanwhile
            @(posedge ref_clk);
            evtValid <= 1'b1;
            evtType <= 8'h01;
            @(negedge ref_clk);
            check(evtDropped, 1'b1);
            @(posedge ref_clk);
            evtValid <= 1'b0;
            repeat (MAXR - 1) begin
                wait_rpt(1100);
                check(link.rptXact, expXact);
                @(negedge ref_clk);
            end
            repeat (1030) begin
                @(negedge ref_clk);
                check(link.ackValid, 1'b0);
            end
            check(doneCode, 2'h3);
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32483));
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        check(doneCode, 2'h0);
        foreach (legal[i]) run_evt(legal[i], 2'h0, 1'b1);
        foreach (rsv[i]) run_evt(rsv[i], 2'h0, 1'b1);
        run_evt(8'h03, 2'h0, 1'b0);
        run_evt(8'h1B, 2'h3, 1'b1);
        run_evt(8'h19, 2'h1, 1'b0);
        // frozen clock enable: an event offered then is dropped, never latched
        @(posedge ref_clk);
        clkEn <= 1'b0;
        evtType <= 8'h05;
        evtValid <= 1'b1;
        @(negedge ref_clk);
        check(evtTaken, 1'b0);
        check(evtDropped, 1'b1);
        @(posedge ref_clk);
        evtValid <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clkEn <= 1'b1;
        repeat (3) begin
            @(negedge ref_clk);
            check(link.rptValid, 1'b0);
        end
        repeat (30) begin
            run_evt(legal[$urandom % 19], ($urandom % 8 == 7) ? 2'h2 : 2'($urandom % 2),
                1'b1);
        end
        end_sim();
    end
endmodule
`default_nettype wire
